// ==== rtl/bdfm_pkg.sv ====
package bdfm_pkg;
	// timing figures in their own units, cycle counts derived at 200 MHz
	localparam int CLK_MHZ         = 200;
	localparam int DEAD_NS         = 50;                              // least dead time
	localparam int DEAD_CYC        = (DEAD_NS * CLK_MHZ + 999) / 1000; // rounded up
	localparam int BLANK_NS        = 1500;                            // overcurrent blanking
	localparam int BLANK_CYC       = (BLANK_NS * CLK_MHZ) / 1000;
	localparam int SHORT_NS        = 12000;                           // short detection delay
	localparam int SHORT_CYC       = (SHORT_NS * CLK_MHZ) / 1000;
	localparam int OV_FILT_NS      = 30000;                           // overvoltage filter, least
	localparam int OV_FILT_CYC     = (OV_FILT_NS * CLK_MHZ + 999) / 1000;
	localparam int RESET_NS        = 2000;                            // drive-permit low time
	localparam int RESET_CYC       = (RESET_NS * CLK_MHZ + 999) / 1000;
	localparam int SC_UP           = 4;                               // integrator charge step
	localparam int SC_DN           = 1;                               // integrator discharge step
	localparam int SC_TRIP         = SHORT_CYC * SC_UP;
	localparam int PHASES          = 3;
	// fault code on the two pins {hi,lo}
	localparam logic [1:0] CODE_UV   = 2'h0;
	localparam logic [1:0] CODE_OT   = 2'h1;
	localparam logic [1:0] CODE_SC   = 2'h2;
	localparam logic [1:0] CODE_NONE = 2'h3;
endpackage

// ==== rtl/bdfm_core.sv ====
// Overview of operation
// - each half bridge has one shared short integrator for both switches
// - confirmed short turns all gates off, latched until drive-permit reset
// - drain voltage watched only after gate command on and dead time over
// - short threshold at disable level turns off short protection only
// - overcurrent comparator blanked about 1.5 us before it reports
// - overcurrent only warns, keeps driving, clears when current drops
// - overcurrent warning drops when current commutates to the high side
// - minimum dead time enforced whatever the command timing
// - dead time lies between 50 and 200 ns
// - both switches of one bridge commanded on is ignored
// - pump buffer undervoltage pulls gates low, stops short detection
// - undervoltage recovery resumes driving without a reset
// - filtered overvoltage turns off gates and pumps, latched until reset
// - overvoltage must persist 30 to 65 us before shutdown
// - after overvoltage the collapsed pumps show as undervoltage code
// - over-temperature only warns and clears itself
// - supply check armed by drive-permit rising edge, idle while low
// - supply check fault disables and latches outputs until reset
// - fault pins encode undervoltage, temperature, short, or no fault
// - several faults report by fixed priority order
// - no fault enters sleep; only the sleep control input does
// - drive-permit held low clears latches and turns all gates off
// - while drive-permit low, only undervoltage and temperature shown
`timescale 1ns/1ps
`default_nettype none
module bdfm_core #(
	parameter int PHASES      = bdfm_pkg::PHASES,
	parameter int OV_FILT_CYC = bdfm_pkg::OV_FILT_CYC,
	parameter int SHORT_CYC   = bdfm_pkg::SHORT_CYC
) (
	input  wire logic              clk_sys,
	input  wire logic              nrst,
	input  wire logic [PHASES-1:0] cmd_high_in,
	input  wire logic [PHASES-1:0] cmd_low_in,
	input  wire logic              drive_permit_in,
	input  wire logic              sleep_control_in,
	input  wire logic [PHASES-1:0] drain_high_over,
	input  wire logic [PHASES-1:0] drain_low_over,
	input  wire logic              short_threshold_level_in,
	input  wire logic              overcurrent_cmp,
	input  wire logic              overcurrent_threshold_in,
	input  wire logic [PHASES-1:0] pump_buffer_caps,
	input  wire logic              supply_over,
	input  wire logic              high_drain_sense,
	input  wire logic              temp_over,
	input  wire logic              io_supply_check,
	output logic      [PHASES-1:0] gate_high,
	output logic      [PHASES-1:0] gate_low,
	output logic                   pump_enable,
	output logic                   fault_code_hi,
	output logic                   fault_code_lo,
	output logic                   sleep_out
);
	localparam int CW = $clog2(bdfm_pkg::SC_UP * SHORT_CYC + bdfm_pkg::SC_UP + 1);
	localparam logic [CW-1:0] TRIP = CW'(bdfm_pkg::SC_UP * SHORT_CYC);
	localparam logic [CW-1:0] UP   = CW'(bdfm_pkg::SC_UP);
	localparam logic [CW-1:0] DN   = CW'(bdfm_pkg::SC_DN);
	localparam logic [CW-1:0] CMAX = {CW{1'b1}};

	typedef struct packed {
		logic [PHASES-1:0][CW-1:0] integ;
		logic [PHASES-1:0][3:0]    dt_hi;
		logic [PHASES-1:0][3:0]    dt_lo;
		logic [PHASES-1:0]         g_hi;
		logic [PHASES-1:0]         g_lo;
		logic [15:0]               blank;
		logic [15:0]               ov_cnt;
		logic [15:0]               rst_cnt;
		logic                      sc_lat;
		logic                      ov_lat;
		logic                      chk_lat;
		logic                      chk_arm;
		logic                      permit_d;
		logic                      oc_warn;
		logic                      pump_en;
		logic [1:0]                code;
		logic                      sleep;
	} bdfm_state_t;

	bdfm_state_t st_r;
	bdfm_state_t st_nxt;
	logic        uv_any;
	logic        shut;
	logic        sc_en;

	// any pump undervoltage or overvoltage pump collapse reads as undervoltage
	assign uv_any = (|pump_buffer_caps) | st_r.ov_lat;
	assign shut   = st_r.sc_lat | st_r.ov_lat | st_r.chk_lat | uv_any | ~drive_permit_in;
	assign sc_en  = ~short_threshold_level_in;

	always_comb
	begin
		st_nxt = st_r;
		// per bridge: dead time, interlock, short integrator
		for (int i = 0; i < PHASES; i++)
		begin
			// dead time counts after the opposite gate went off
			st_nxt.dt_hi[i] = st_r.g_lo[i] ? 4'h0 : (st_r.dt_hi[i] < 4'(bdfm_pkg::DEAD_CYC) ?
				st_r.dt_hi[i] + 4'h1 : st_r.dt_hi[i]);
			st_nxt.dt_lo[i] = st_r.g_hi[i] ? 4'h0 : (st_r.dt_lo[i] < 4'(bdfm_pkg::DEAD_CYC) ?
				st_r.dt_lo[i] + 4'h1 : st_r.dt_lo[i]);
			// both commanded is ignored: both gates off
			st_nxt.g_hi[i] = ~shut & cmd_high_in[i] & ~cmd_low_in[i] & ~st_r.g_lo[i]
				& (st_r.dt_hi[i] >= 4'(bdfm_pkg::DEAD_CYC));
			st_nxt.g_lo[i] = ~shut & cmd_low_in[i] & ~cmd_high_in[i] & ~st_r.g_hi[i]
				& (st_r.dt_lo[i] >= 4'(bdfm_pkg::DEAD_CYC));
			// shared integrator, only watching a gate that is on after dead time
			if (sc_en & ~pump_buffer_caps[i] &
				((st_r.g_hi[i] & drain_high_over[i]) | (st_r.g_lo[i] & drain_low_over[i])))
				st_nxt.integ[i] = (st_r.integ[i] > CMAX - UP) ? CMAX : st_r.integ[i] + UP;
			else
				st_nxt.integ[i] = (st_r.integ[i] < DN) ? '0 : st_r.integ[i] - DN;
			// a stage in undervoltage or with protection off must not trip on old charge
			if (sc_en & ~pump_buffer_caps[i] & (st_r.integ[i] >= TRIP))
				st_nxt.sc_lat = 1'b1;
		end
		// overcurrent blanking; low side off means no shunt current
		if (overcurrent_cmp & overcurrent_threshold_in & (|st_r.g_lo))
			st_nxt.blank = (st_r.blank < 16'(bdfm_pkg::BLANK_CYC)) ? st_r.blank + 16'h1 : st_r.blank;
		else
			st_nxt.blank = 16'h0;
		st_nxt.oc_warn = (st_r.blank >= 16'(bdfm_pkg::BLANK_CYC));
		// overvoltage filter
		if (supply_over | high_drain_sense)
			st_nxt.ov_cnt = (st_r.ov_cnt < 16'(OV_FILT_CYC)) ? st_r.ov_cnt + 16'h1 : st_r.ov_cnt;
		else
			st_nxt.ov_cnt = 16'h0;
		if (st_r.ov_cnt >= 16'(OV_FILT_CYC))
			st_nxt.ov_lat = 1'b1;
		st_nxt.pump_en = ~st_nxt.ov_lat;
		// supply check armed by permit edge
		st_nxt.permit_d = drive_permit_in;
		st_nxt.chk_arm  = drive_permit_in & (st_r.chk_arm | ~st_r.permit_d);
		if (st_r.chk_arm & drive_permit_in & io_supply_check)
			st_nxt.chk_lat = 1'b1;
		// permit low long enough clears latches
		st_nxt.rst_cnt = drive_permit_in ? 16'h0 :
			((st_r.rst_cnt < 16'(bdfm_pkg::RESET_CYC)) ? st_r.rst_cnt + 16'h1 : st_r.rst_cnt);
		if (st_r.rst_cnt >= 16'(bdfm_pkg::RESET_CYC))
		begin
			st_nxt.sc_lat  = 1'b0;
			st_nxt.ov_lat  = 1'b0;
			st_nxt.chk_lat = 1'b0;
		end
		// fault code by priority; disabled shows only uv and temperature
		if (drive_permit_in & st_r.chk_lat)
			st_nxt.code = bdfm_pkg::CODE_UV;
		else if (drive_permit_in & st_r.sc_lat)
			st_nxt.code = bdfm_pkg::CODE_SC;
		else if (uv_any)
			st_nxt.code = bdfm_pkg::CODE_UV;
		else if (drive_permit_in & st_r.ov_lat)
			st_nxt.code = bdfm_pkg::CODE_OT;
		else if (temp_over)
			st_nxt.code = bdfm_pkg::CODE_OT;
		else if (drive_permit_in & st_r.oc_warn)
			st_nxt.code = bdfm_pkg::CODE_SC;
		else
			st_nxt.code = bdfm_pkg::CODE_NONE;
		// sleep follows only its own input, never a fault
		st_nxt.sleep = sleep_control_in;
	end

	// single state register
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			st_r          <= '0;
			st_r.pump_en  <= 1'b1;
			st_r.code     <= bdfm_pkg::CODE_NONE;
		end
		else
			st_r <= st_nxt;
	end

	assign gate_high     = st_r.g_hi;
	assign gate_low      = st_r.g_lo;
	assign pump_enable   = st_r.pump_en;
	assign fault_code_hi = st_r.code[1];
	assign fault_code_lo = st_r.code[0];
	assign sleep_out     = st_r.sleep;

	// interlock: never both gates of a bridge
	a_no_shoot_thru: assert property (@(posedge clk_sys) disable iff (!nrst)
		(gate_high & gate_low) == '0) else $error("both gates on");
	// dead time: bridge 0 high gate turns on only after its low gate was off for the two cycles before
	a_dead_gap: assert property (@(posedge clk_sys) disable iff (!nrst)
		$rose(gate_high[0]) |-> !$past(gate_low[0], 1) && !$past(gate_low[0], 2))
		else $error("dead time short");
	// short latch keeps gates off until permit reset
	a_short_off: assert property (@(posedge clk_sys) disable iff (!nrst)
		st_r.sc_lat |=> (gate_high == '0 && gate_low == '0) || !st_r.sc_lat)
		else $error("gate on after short");
	// disabled short protection never latches
	a_short_dis: assert property (@(posedge clk_sys) disable iff (!nrst)
		(short_threshold_level_in && !st_r.sc_lat) [*3] |=> !st_r.sc_lat)
		else $error("short latched while disabled");
	// overvoltage latch turns pumps off
	a_ov_pump: assert property (@(posedge clk_sys) disable iff (!nrst)
		$rose(st_r.ov_lat) |=> !pump_enable) else $error("pump on after overvoltage");
	// overvoltage shows as undervoltage code
	a_ov_code: assert property (@(posedge clk_sys) disable iff (!nrst)
		st_r.ov_lat && !st_r.chk_lat && !st_r.sc_lat |=> fault_code_hi == 1'b0 && fault_code_lo == 1'b0)
		else $error("overvoltage not coded");
	// disabled: only uv, temperature or none may show
	a_disable_code: assert property (@(posedge clk_sys) disable iff (!nrst)
		!drive_permit_in && $past(!drive_permit_in) |-> {fault_code_hi, fault_code_lo} != bdfm_pkg::CODE_SC)
		else $error("short code while disabled");
	// long permit low clears the short and supply check latches
	a_reset_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
		st_r.rst_cnt >= 16'(bdfm_pkg::RESET_CYC) |=> !st_r.sc_lat && !st_r.chk_lat)
		else $error("latch not cleared");
	// undervoltage pulls gates off
	a_uv_off: assert property (@(posedge clk_sys) disable iff (!nrst)
		(|pump_buffer_caps) |=> gate_high == '0 && gate_low == '0) else $error("gate on in uv");

	// per-bridge checks; the repeated gap below is ten cycles, the least dead time
	generate
		for (genvar b = 0; b < PHASES; b++)
		begin : g_bridge_chk
			logic overload;

			// some drain above its limit while that switch conducts
			assign overload = (gate_high[b] & drain_high_over[b]) | (gate_low[b] & drain_low_over[b]);

			// high side held off for the whole gap after the low side released
			sequence s_high_gap;
				(!gate_high[b]) [*8] ##1 (!gate_high[b]) [*2];
			endsequence
			// low side held off for the whole gap after the high side released
			sequence s_low_gap;
				(!gate_low[b]) [*8] ##1 (!gate_low[b]) [*2];
			endsequence

			a_dead_high: assert property (@(posedge clk_sys) disable iff (!nrst)
				$fell(gate_low[b]) |-> s_high_gap)
				else $error("high side inside dead time");
			a_dead_low: assert property (@(posedge clk_sys) disable iff (!nrst)
				$fell(gate_high[b]) |-> s_low_gap)
				else $error("low side inside dead time");

			// near the top the integrator saturates instead of wrapping
			a_integ_sat: assert property (@(posedge clk_sys) disable iff (!nrst)
				st_r.integ[b] >= CMAX - UP |=> st_r.integ[b] >= CMAX - UP - DN)
				else $error("integrator wrapped");
			// both switches off: nothing watched, only the slow discharge
			a_integ_down: assert property (@(posedge clk_sys) disable iff (!nrst)
				!gate_high[b] && !gate_low[b] && st_r.integ[b] >= DN
				|=> st_r.integ[b] == $past(st_r.integ[b]) - DN)
				else $error("integrator not discharging");
			// either switch of the bridge charges the one shared integrator
			a_integ_up: assert property (@(posedge clk_sys) disable iff (!nrst)
				!short_threshold_level_in && !pump_buffer_caps[b] && overload && st_r.integ[b] <= CMAX - UP
				|=> st_r.integ[b] == $past(st_r.integ[b]) + UP)
				else $error("integrator not charging");
			// undervoltage on this stage stops charging, so no latching trip
			a_uv_no_charge: assert property (@(posedge clk_sys) disable iff (!nrst)
				pump_buffer_caps[b] && st_r.integ[b] >= DN
				|=> st_r.integ[b] == $past(st_r.integ[b]) - DN)
				else $error("integrator charging in uv");
			// integrator at trip level with protection live sets the latch
			a_trip_latch: assert property (@(posedge clk_sys) disable iff (!nrst)
				!short_threshold_level_in && !pump_buffer_caps[b] && st_r.integ[b] >= TRIP
				&& st_r.rst_cnt < 16'(bdfm_pkg::RESET_CYC) |=> st_r.sc_lat)
				else $error("short not latched");
			// warnings never stop a bridge that is driven and free of shut-downs
			a_drive_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
				drive_permit_in && !st_r.sc_lat && !st_r.ov_lat && !st_r.chk_lat && !(|pump_buffer_caps)
				&& gate_low[b] && cmd_low_in[b] && !cmd_high_in[b] |=> gate_low[b])
				else $error("low side dropped");
		end
	endgenerate

	// quiet comparator restarts blanking, so no warning for many cycles
	sequence s_warn_quiet;
		##2 (!st_r.oc_warn) [*8];
	endsequence

	a_oc_blank: assert property (@(posedge clk_sys) disable iff (!nrst)
		!overcurrent_cmp |-> s_warn_quiet)
		else $error("warning without blanking");

	// no low side on means no shunt current and no warning
	a_oc_commute: assert property (@(posedge clk_sys) disable iff (!nrst)
		!(|gate_low) |-> ##2 !st_r.oc_warn)
		else $error("warning after commutation");

	// threshold pin at ground switches the warning off
	a_oc_off: assert property (@(posedge clk_sys) disable iff (!nrst)
		!overcurrent_threshold_in |-> ##2 !st_r.oc_warn)
		else $error("warning while disabled");

	// supply check outranks every other code
	a_check_first: assert property (@(posedge clk_sys) disable iff (!nrst)
		drive_permit_in && st_r.chk_lat |=> {fault_code_hi, fault_code_lo} == bdfm_pkg::CODE_UV)
		else $error("check fault not shown");

	// short outranks undervoltage and the warnings
	a_short_code: assert property (@(posedge clk_sys) disable iff (!nrst)
		drive_permit_in && st_r.sc_lat && !st_r.chk_lat |=> {fault_code_hi, fault_code_lo} == bdfm_pkg::CODE_SC)
		else $error("short not shown");

	// temperature shows when nothing above it stands
	a_temp_warn: assert property (@(posedge clk_sys) disable iff (!nrst)
		temp_over && !(|pump_buffer_caps) && !st_r.ov_lat
		&& !(drive_permit_in && (st_r.sc_lat || st_r.chk_lat))
		|=> {fault_code_hi, fault_code_lo} == bdfm_pkg::CODE_OT)
		else $error("temperature not shown");

	// nothing pending reads as no fault
	a_none_code: assert property (@(posedge clk_sys) disable iff (!nrst)
		!st_r.sc_lat && !st_r.ov_lat && !st_r.chk_lat && !(|pump_buffer_caps) && !temp_over && !st_r.oc_warn
		|=> {fault_code_hi, fault_code_lo} == bdfm_pkg::CODE_NONE)
		else $error("false fault code");

	// undervoltage still shows while disabled
	a_uv_disabled: assert property (@(posedge clk_sys) disable iff (!nrst)
		!drive_permit_in && (|pump_buffer_caps) |=> {fault_code_hi, fault_code_lo} == bdfm_pkg::CODE_UV)
		else $error("uv hidden while disabled");

	// disabled with no uv or temperature shows nothing, latches hidden
	a_quiet_disabled: assert property (@(posedge clk_sys) disable iff (!nrst)
		!drive_permit_in && !(|pump_buffer_caps) && !st_r.ov_lat && !temp_over
		|=> {fault_code_hi, fault_code_lo} == bdfm_pkg::CODE_NONE)
		else $error("latch shown while disabled");

	// sleep only follows its own pin, one cycle late
	a_sleep_follow: assert property (@(posedge clk_sys) disable iff (!nrst)
		sleep_out == $past(sleep_control_in))
		else $error("sleep not following pin");

	// check disarmed while permit is low
	a_chk_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
		!drive_permit_in |=> !st_r.chk_arm)
		else $error("check armed while disabled");

	// check fault holds gates off until the long permit low
	a_chk_latch: assert property (@(posedge clk_sys) disable iff (!nrst)
		st_r.chk_lat && st_r.rst_cnt < 16'(bdfm_pkg::RESET_CYC)
		|=> st_r.chk_lat && gate_high == '0 && gate_low == '0)
		else $error("check latch lost");

	// overvoltage latch keeps pumps off until the long permit low
	a_ov_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
		st_r.ov_lat && st_r.rst_cnt < 16'(bdfm_pkg::RESET_CYC) |=> st_r.ov_lat && !pump_enable)
		else $error("overvoltage latch lost");

	// two quiet cycles leave the filter empty, so no latch can follow
	a_ov_filter: assert property (@(posedge clk_sys) disable iff (!nrst)
		(!supply_over && !high_drain_sense && !st_r.ov_lat) [*2] |=> !st_r.ov_lat)
		else $error("overvoltage latched without filter");

	// permit low switches every gate off actively
	a_permit_off: assert property (@(posedge clk_sys) disable iff (!nrst)
		!drive_permit_in |=> gate_high == '0 && gate_low == '0)
		else $error("gate on while disabled");
endmodule // bdfm_core
`default_nettype wire

// ==== bench/bdfm_bridge_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module bdfm_bridge_model (
	input  wire logic       clk_sys,
	input  wire logic [2:0] gate_high,
	input  wire logic [2:0] gate_low,
	input  wire logic       pump_enable,
	input  wire logic [2:0] short_on,
	input  wire logic       heavy_load,
	input  wire logic [2:0] uv_force,
	output logic      [2:0] drain_high_over,
	output logic      [2:0] drain_low_over,
	output logic            overcurrent_cmp,
	output var logic  [2:0] pump_buffer_caps
);
	// a shorted leg shows high drain voltage only while its switch conducts
	assign drain_high_over = gate_high & short_on;
	assign drain_low_over  = gate_low & short_on;
	// shunt current exists only through low side switches
	assign overcurrent_cmp = heavy_load & (|gate_low);
	// buffers sag once pumps stop; one cycle stands in for the discharge
	always_ff @(posedge clk_sys)
	begin
		pump_buffer_caps <= uv_force | {3{~pump_enable}};
	end
endmodule // bdfm_bridge_model
`default_nettype wire

// ==== bench/bdfm_core_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin @(negedge clk_sys); checks++; if ((g) !== (e)) begin err_total++; $display("Error %s expected %h seen %h", n, e, g); end end
module bdfm_core_tb_top;
	localparam int OV  = 20;
	localparam int SC  = 10;
	localparam int RST = bdfm_pkg::RESET_CYC;
	logic       clk_sys = 1'h0, nrst = 1'h0, drive_permit_in = 1'h1, sleep_control_in = 1'h0, heavy = 1'h0;
	logic       short_threshold_level_in = 1'h0, overcurrent_threshold_in = 1'h1, temp_over = 1'h0;
	logic       supply_over = 1'h0, high_drain_sense = 1'h0, io_supply_check = 1'h0;
	logic [2:0] cmd_high_in = 3'h0, cmd_low_in = 3'h0, short_on = 3'h0, uv_force = 3'h0;
	logic [2:0] gate_high, gate_low, drain_high_over, drain_low_over, pump_buffer_caps;
	logic       pump_enable, fault_code_hi, fault_code_lo, sleep_out, overcurrent_cmp;
	logic [1:0] code;
	int         err_total = 0, checks = 0, cycles = 0;
	assign code = {fault_code_hi, fault_code_lo};
	// short filter counts keep the run brief
	bdfm_core #(.PHASES(3), .OV_FILT_CYC(OV), .SHORT_CYC(SC)) bdfm_core_i (.clk_sys, .nrst, .cmd_high_in,
		.cmd_low_in, .drive_permit_in, .sleep_control_in, .drain_high_over, .drain_low_over,
		.short_threshold_level_in, .overcurrent_cmp, .overcurrent_threshold_in, .pump_buffer_caps,
		.supply_over, .high_drain_sense, .temp_over, .io_supply_check, .gate_high, .gate_low,
		.pump_enable, .fault_code_hi, .fault_code_lo, .sleep_out);
	bdfm_bridge_model bdfm_bridge_model_i (.clk_sys, .gate_high, .gate_low, .pump_enable, .short_on,
		.heavy_load(heavy), .uv_force, .drain_high_over, .drain_low_over, .overcurrent_cmp, .pump_buffer_caps);
	// clock and hang guard
	initial
	begin
		forever #2.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			err_total++;
			close_out();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// full clear needs the permit held low past the minimum
	task automatic permit_reset();
		tick(1);
		drive_permit_in <= 1'h0;
		tick(RST + 10);
		drive_permit_in <= 1'h1;
		tick(15);
	endtask
	task automatic t_basic();
		`CHK("idle code", 2'h3, code)
		tick(1);
		temp_over <= 1'h1;
		tick(3);
		`CHK("warm code", 2'h1, code)
		`CHK("no sleep", 1'h0, sleep_out)
		tick(1);
		temp_over <= 1'h0;
		sleep_control_in <= 1'h1;
		tick(3);
		`CHK("sleep", 1'h1, sleep_out)
		`CHK("cool code", 2'h3, code)
		tick(1);
		sleep_control_in <= 1'h0;
		$display("basic done");
	endtask
	// back-to-back hand-over with no gap from the controller
	task automatic t_dead();
		tick(1);
		cmd_high_in <= 3'h1;
		tick(2);
		`CHK("high on", 3'h1, gate_high)
		tick(1);
		cmd_high_in <= 3'h0;
		cmd_low_in <= 3'h1;
		tick(3);
		`CHK("low held", 3'h0, gate_low)
		tick(12);
		`CHK("low on", 3'h1, gate_low)
		tick(1);
		cmd_high_in <= 3'h1;
		tick(3);
		`CHK("both", 6'h00, {gate_high, gate_low})
		tick(1);
		cmd_high_in <= 3'h0;
		cmd_low_in <= 3'h2;
		$display("dead time done");
	endtask
	task automatic t_short();
		tick(1);
		short_threshold_level_in <= 1'h1;
		short_on <= 3'h2;
		tick(50);
		`CHK("sc off", 3'h2, gate_low)
		tick(1);
		short_threshold_level_in <= 1'h0;
		tick(30);
		`CHK("sc trip", 3'h0, gate_low)
		`CHK("sc code", 2'h2, code)
		tick(1);
		short_on <= 3'h0;
		uv_force <= 3'h1;
		tick(30);
		`CHK("sc over uv", 2'h2, code)
		tick(1);
		uv_force <= 3'h0;
		temp_over <= 1'h1;
		drive_permit_in <= 1'h0;
		tick(5);
		`CHK("low permit", 2'h1, code)
		`CHK("gates off", 3'h0, gate_low)
		tick(RST + 5);
		drive_permit_in <= 1'h1;
		temp_over <= 1'h0;
		tick(15);
		`CHK("cleared", 2'h3, code)
		`CHK("resumed", 3'h2, gate_low)
		$display("short done");
	endtask
	task automatic t_oc();
		tick(1);
		heavy <= 1'h1;
		tick(100);
		`CHK("blanked", 2'h3, code)
		tick(250);
		`CHK("oc code", 2'h2, code)
		`CHK("oc drives", 3'h2, gate_low)
		tick(1);
		cmd_low_in <= 3'h0;
		cmd_high_in <= 3'h2;
		tick(15);
		`CHK("commutated", 2'h3, code)
		tick(1);
		cmd_high_in <= 3'h0;
		cmd_low_in <= 3'h2;
		overcurrent_threshold_in <= 1'h0; // warning switched off
		tick(400);
		`CHK("oc disabled", 2'h3, code)
		tick(1);
		heavy <= 1'h0;
		overcurrent_threshold_in <= 1'h1;
		$display("overcurrent done");
	endtask
	task automatic t_uv_ov();
		tick(1);
		temp_over <= 1'h1;
		uv_force <= 3'h4;
		tick(50);
		`CHK("uv gates", 3'h0, gate_low)
		`CHK("uv code", 2'h0, code)
		tick(1);
		uv_force <= 3'h0;
		temp_over <= 1'h0;
		tick(50);
		`CHK("uv back", 3'h2, gate_low)
		for (int i = 0; i < 2; i++)
		begin
			tick(1);
			supply_over <= (i == 0);
			high_drain_sense <= (i == 1);
			tick(5);
			`CHK("ov filter", 1'h1, pump_enable)
			tick(OV + 10);
			`CHK("ov pump", 1'h0, pump_enable)
			`CHK("ov gates", 3'h0, gate_low)
			`CHK("ov code", 2'h0, code)
			tick(1);
			supply_over <= 1'h0;
			high_drain_sense <= 1'h0;
			tick(20);
			`CHK("ov latch", 1'h0, pump_enable)
			permit_reset();
			`CHK("ov clear", 3'h2, gate_low)
		end
		$display("supply done");
	endtask
	task automatic t_io();
		tick(1);
		io_supply_check <= 1'h1;
		tick(10);
		`CHK("io code", 2'h0, code)
		tick(1);
		io_supply_check <= 1'h0;
		tick(10);
		`CHK("io latch", 3'h0, gate_low)
		tick(1);
		drive_permit_in <= 1'h0;
		tick(RST + 10);
		io_supply_check <= 1'h1;
		tick(5);
		`CHK("io idle", 2'h3, code)
		tick(1);
		io_supply_check <= 1'h0;
		drive_permit_in <= 1'h1;
		tick(15);
		`CHK("io unarmed", 3'h2, gate_low)
		$display("io check done");
	endtask
	initial
	begin
		tick(3);
		nrst <= 1'h1;
		tick(2);
		t_basic();
		t_dead();
		t_short();
		t_oc();
		t_uv_ov();
		t_io();
		close_out();
	end
endmodule // bdfm_core_tb_top
`default_nettype wire
